// ---- src/upbpc_pkg.sv ----
// upbpc_pkg: offsets, field positions and reset values of the upper
// port pin control block.
// assumes a 32-bit axi4-lite slave with one register per aligned word.
package upbpc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_LEVEL = 8'h00; // pin levels / latch write
  localparam logic [7:0] OFF_LATCH = 8'h04; // output latch
  localparam logic [7:0] OFF_DIR = 8'h08; // direction, 1 = input
  localparam logic [7:0] OFF_ICM = 8'h0C; // interrupt control main
  localparam logic [7:0] OFF_IC2 = 8'h10; // interrupt control second
  localparam logic [7:0] OFF_IC3 = 8'h14; // interrupt control third
  localparam logic [7:0] OFF_ANA = 8'h18; // analog pin config
  localparam logic [7:0] OFF_FSEL = 8'h1C; // function select
  localparam logic [7:0] OFF_ISTAT = 8'h20; // sticky event status
  localparam logic [7:0] OFF_ICLR = 8'h24; // write one to clear
  localparam logic [7:0] OFF_IEN = 8'h28; // interrupt enable
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ICM_FLAG = 0; // port change flag
  localparam int ICM_EN = 3; // port change enable
  localparam int IC2_PRIO = 0; // port change priority, 1 = high
  localparam int IC2_PUDN = 7; // global pull-up disable
  localparam int ANA_LINE4 = 4; // 1 = line 4 digital
  localparam int SEL_SERIAL_I2C = 8; // serial module in two-wire mode
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hF0; // upper lines inputs
  localparam logic [7:0] RST_IC2 = 8'h80; // pull-ups off
  localparam logic [7:0] RST_IC3 = 8'h00; // plain storage, cleared
  localparam logic [7:0] RST_ANA = 8'h00; // shared lines analog
  localparam logic [8:0] RST_FSEL = 9'h000; // all lines plain port
  // ------------------------------------------------------------
  // per-line function codes, two bits per line
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    UPBPC_FN_PORT = 2'h0,
    UPBPC_FN_REMAP = 2'h1,
    UPBPC_FN_SERIAL = 2'h2,
    UPBPC_FN_PARADDR = 2'h3
  } upbpc_fn_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : upbpc_pkg

// ---- src/upbpc_top.sv ----
// upbpc_top: pin control for lines 4..7 of an 8-bit bidirectional port,
// with axi4-lite registers, change interrupt and function muxing.
// assumes pin inputs already synchronous to aclk; pads resolve the wire.
//
// Behaviour
// [RL1] direction 0 drives pin from latch
// [RL2] direction 1 reads pin level back
// [RL3] pull-up on inputs unless global disable set
// [RL4] shared analog lines reset to analog
// [RL5] analog line 4 kills buffer and pull-up
// [RL6] programming mode disables other functions there
// [RL7] line 6 is programming clock input
// [RL8] line 7 programming data, direction from programmer
// [RL9] don't-care functions override the direction bit
// [RL10] large package: lines 4,5 parallel address
// [RL11] line 4 serial clock follows direction
// [RL12] two-wire lines: input or open-drain output
// [RL13] lines 4..7 are remappable pins 7..10
// [RL14] level change sets flag, enable requests interrupt
// [RL15] second control bit 0 selects priority
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module upbpc_top #(
  parameter bit LARGE_PKG = 1'b1 // parallel address pins present
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads, index 0 is line 4
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe,
  output logic [3:0] pad_pullup_en,
  // peripheral side
  input wire logic [3:0] remap_out,
  input wire logic sync_serial_clock_out,
  input wire logic two_wire_clock_out,
  input wire logic two_wire_data_out,
  input wire logic [1:0] par_addr_out,
  input wire logic prog_mode,
  input wire logic prog_data_out,
  input wire logic prog_data_drive,
  output logic [3:0] periph_in,
  // interrupts
  output logic irq,
  output logic irq_high,
  output logic irq_low
);
  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (LARGE_PKG !== 1'b0 && LARGE_PKG !== 1'b1) begin : g_chk
    $error("upbpc_top: LARGE_PKG must be 0 or 1");
  end

  // decoded access to one offset
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] latch_q; // line_output_latch
  logic [7:0] dir_q; // line_direction
  logic [7:0] ic2_q; // interrupt control second
  logic [7:0] ic3_q; // interrupt control third, stored only
  logic [7:0] ana_q; // analog_select_bits
  logic [8:0] fsel_q; // function select + serial mode
  logic icm_en_q; // port_change_irq_enable
  logic flag_q; // port_change_irq_flag, also status bit 0
  logic ien_q; // status enable bit 0
  logic [3:0] lvl_q; // previous sampled levels
  // bus state
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;

  // ------------------------------------------------------------
  // write channel decode
  // ------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_b0 = wr_go & ws_q[0];
  wire [7:0] wd = w_q[7:0];
  wire wr_known = hit(aw_q, upbpc_pkg::OFF_LEVEL) |
                  hit(aw_q, upbpc_pkg::OFF_LATCH) |
                  hit(aw_q, upbpc_pkg::OFF_DIR) |
                  hit(aw_q, upbpc_pkg::OFF_ICM) |
                  hit(aw_q, upbpc_pkg::OFF_IC2) |
                  hit(aw_q, upbpc_pkg::OFF_IC3) |
                  hit(aw_q, upbpc_pkg::OFF_ANA) |
                  hit(aw_q, upbpc_pkg::OFF_FSEL) |
                  hit(aw_q, upbpc_pkg::OFF_ICLR) |
                  hit(aw_q, upbpc_pkg::OFF_IEN);
  // writing the level register lands in the latch, as on a real port
  wire wr_latch = wr_b0 & (hit(aw_q, upbpc_pkg::OFF_LEVEL) |
                           hit(aw_q, upbpc_pkg::OFF_LATCH));
  wire wr_dir = wr_b0 & hit(aw_q, upbpc_pkg::OFF_DIR);
  wire wr_icm = wr_b0 & hit(aw_q, upbpc_pkg::OFF_ICM);
  wire wr_ic2 = wr_b0 & hit(aw_q, upbpc_pkg::OFF_IC2);
  wire wr_ic3 = wr_b0 & hit(aw_q, upbpc_pkg::OFF_IC3);
  wire wr_ana = wr_b0 & hit(aw_q, upbpc_pkg::OFF_ANA);
  wire wr_fsel = wr_go & hit(aw_q, upbpc_pkg::OFF_FSEL);
  wire wr_iclr = wr_b0 & hit(aw_q, upbpc_pkg::OFF_ICLR);
  wire wr_ien = wr_b0 & hit(aw_q, upbpc_pkg::OFF_IEN);

  // ------------------------------------------------------------
  // pin level path
  // ------------------------------------------------------------
  // line 4 input buffer off while it is still analog
  wire line4_analog = ~ana_q[upbpc_pkg::ANA_LINE4]; // RL4
  wire [3:0] buf_en = {3'b111, ~line4_analog}; // RL5
  wire [3:0] lvl_now = pad_in & buf_en; // RL2
  // only input lines count for change detection
  wire [3:0] chg = (lvl_now ^ lvl_q) & dir_q[7:4];
  wire chg_evt = |chg; // RL14
  // set beats clear in the same cycle
  wire icm_clr = wr_icm & ~wd[upbpc_pkg::ICM_FLAG];
  wire flag_d = chg_evt | (flag_q & ~icm_clr &
                ~(wr_iclr & wd[0])); // RL14

  // ------------------------------------------------------------
  // pin drive selection
  // ------------------------------------------------------------
  wire [1:0] fn [4];
  assign fn[0] = fsel_q[1:0];
  assign fn[1] = fsel_q[3:2];
  assign fn[2] = fsel_q[5:4];
  assign fn[3] = fsel_q[7:6];
  wire i2c_mode = fsel_q[upbpc_pkg::SEL_SERIAL_I2C];
  logic [3:0] out_d;
  logic [3:0] oe_d;
  logic [3:0] pu_d;

  // per-line function mux
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      // default: plain port, direction bit decides
      out_d[k] = latch_q[4+k]; // RL1
      oe_d[k] = ~dir_q[4+k]; // RL1
      case (fn[k])
        upbpc_pkg::UPBPC_FN_REMAP: begin
          out_d[k] = remap_out[k]; // RL13
        end
        upbpc_pkg::UPBPC_FN_SERIAL: begin
          if (k == 0 && !i2c_mode) begin
            out_d[k] = sync_serial_clock_out; // RL11
          end else if (k == 1 && !i2c_mode) begin
            // serial data in is input only
            oe_d[k] = 1'b0;
          end else if (k < 2) begin
            // open-drain: only ever pull low
            out_d[k] = 1'b0; // RL12
            oe_d[k] = ~dir_q[4+k] & ~(k == 0 ? two_wire_clock_out
                                            : two_wire_data_out);
          end
        end
        upbpc_pkg::UPBPC_FN_PARADDR: begin
          if (LARGE_PKG && k < 2) begin
            out_d[k] = par_addr_out[1-k]; // RL10
          end
        end
        default: begin
        end
      endcase
    end
    // pull-ups only on input lines with buffer active
    pu_d = dir_q[7:4] & buf_en &
           {4{~ic2_q[upbpc_pkg::IC2_PUDN]}}; // RL3 RL5
    // programming mode owns lines 6 and 7
    if (prog_mode) begin
      out_d[2] = 1'b0;
      oe_d[2] = 1'b0; // RL7 RL9
      pu_d[2] = 1'b0; // RL6
      out_d[3] = prog_data_out; // RL8
      oe_d[3] = prog_data_drive; // RL8 RL9
      pu_d[3] = 1'b0; // RL6
    end
  end

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_ok;

  // read mux, reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, upbpc_pkg::OFF_LEVEL)) begin
      rd_byte = {lvl_now, 4'h0}; // RL2
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_LATCH)) begin
      rd_byte = {latch_q[7:4], 4'h0};
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_DIR)) begin
      rd_byte = {dir_q[7:4], 4'h0};
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_ICM)) begin
      rd_byte = {4'h0, icm_en_q, 2'b00, flag_q};
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_IC2)) begin
      rd_byte = ic2_q;
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_IC3)) begin
      rd_byte = ic3_q;
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_ANA)) begin
      rd_byte = ana_q;
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_FSEL)) begin
      rd_byte = fsel_q[7:0];
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_ISTAT)) begin
      rd_byte = {7'h00, flag_q};
    end else if (hit(s_axi_araddr, upbpc_pkg::OFF_IEN)) begin
      rd_byte = {7'h00, ien_q};
    end else if (!hit(s_axi_araddr, upbpc_pkg::OFF_ICLR)) begin
      rd_ok = 1'b0; // unmapped
    end
  end
  wire [8:0] fsel_rd = fsel_q;
  wire [31:0] rd_word = hit(s_axi_araddr, upbpc_pkg::OFF_FSEL) ?
                        {23'h00_0000, fsel_rd} : {24'h00_0000, rd_byte};

  // ------------------------------------------------------------
  // axi write handshake
  // ------------------------------------------------------------
  // one write in flight; address and data may come in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= upbpc_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~aw_full_q & ~aw_take & ~s_axi_bvalid;
      s_axi_wready <= ~w_full_q & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? upbpc_pkg::RESP_OKAY
                                : upbpc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // axi read handshake
  // ------------------------------------------------------------
  // one read in flight; answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= upbpc_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? upbpc_pkg::RESP_OKAY
                             : upbpc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // the low byte lane carries register bits, except function select bit 8 from lane 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= upbpc_pkg::RST_LATCH;
      dir_q <= upbpc_pkg::RST_DIR;
      ic2_q <= upbpc_pkg::RST_IC2;
      ic3_q <= upbpc_pkg::RST_IC3;
      ana_q <= upbpc_pkg::RST_ANA; // RL4
      fsel_q <= upbpc_pkg::RST_FSEL;
      icm_en_q <= 1'b0;
      ien_q <= 1'b0;
    end else if (ce) begin
      if (wr_latch) latch_q <= wd;
      if (wr_dir) dir_q <= wd;
      if (wr_ic2) ic2_q <= wd;
      if (wr_ic3) ic3_q <= wd;
      if (wr_ana) ana_q <= wd;
      if (wr_fsel && ws_q[0]) fsel_q[7:0] <= wd;
      if (wr_fsel && ws_q[1]) fsel_q[8] <= w_q[8];
      if (wr_icm) icm_en_q <= wd[upbpc_pkg::ICM_EN];
      if (wr_ien) ien_q <= wd[0];
    end
  end

  // ------------------------------------------------------------
  // change detect and interrupt outputs
  // ------------------------------------------------------------
  // outputs registered; they lag the flag by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_q <= lvl_now; // track pins so idle-high lines give no false edge
      flag_q <= 1'b0;
      irq <= 1'b0;
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else if (ce) begin
      lvl_q <= lvl_now;
      flag_q <= flag_d; // RL14
      irq <= flag_q & ien_q;
      irq_high <= flag_q & icm_en_q & ic2_q[upbpc_pkg::IC2_PRIO]; // RL15
      irq_low <= flag_q & icm_en_q & ~ic2_q[upbpc_pkg::IC2_PRIO]; // RL15
    end
  end

  // ------------------------------------------------------------
  // pad and peripheral outputs
  // ------------------------------------------------------------
  // one cycle of register delay keeps every output on a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= 4'h0;
      pad_oe <= 4'h0;
      pad_pullup_en <= 4'h0;
      periph_in <= 4'h0;
    end else if (ce) begin
      pad_out <= out_d;
      pad_oe <= oe_d;
      pad_pullup_en <= pu_d;
      periph_in <= lvl_now; // RL13 RL7 RL8
    end
  end
endmodule : upbpc_top

// ---- test/tb_top.sv ----
// tb_top: self-checking bench for upbpc_top over axi4-lite and pads.
// assumes the bind in upbpc_assertions.sv; pads driven by the bench.
`timescale 1ns/1ns
module tb_top;
  // ------------------------------------------------------------
  // signals, named as the design ports
  // ------------------------------------------------------------
  logic aclk, aresetn, ce;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, pad_in, pad_out, pad_oe, pad_pullup_en;
  logic [3:0] remap_out, periph_in;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, par_addr_out;
  logic sync_serial_clock_out, two_wire_clock_out, two_wire_data_out;
  logic prog_mode, prog_data_out, prog_data_drive, irq, irq_high, irq_low;
  int bad_count = 0; // mismatches
  int samples_checked = 0; // comparisons

  upbpc_top u_upbpc_top (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in,
    .pad_out, .pad_oe, .pad_pullup_en, .remap_out, .sync_serial_clock_out,
    .two_wire_clock_out, .two_wire_data_out, .par_addr_out, .prog_mode,
    .prog_data_out, .prog_data_drive, .periph_in, .irq, .irq_high,
    .irq_low);

  // ------------------------------------------------------------
  // common tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // a handshake that never comes ends the run
  task automatic give_up();
    bad_count++;
    $display("MISMATCH handshake expected 1 seen 0");
    report_and_stop();
  endtask : give_up

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : wt

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk("bresp", 32'(s_axi_bresp), 32'(upbpc_pkg::RESP_OKAY));
    s_axi_bready <= 1'b0;
    if (n == 40) give_up();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) give_up();
  endtask : rd

  task automatic rck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(upbpc_pkg::RESP_OKAY));
  endtask : rck

  // function select plus direction, then pad drive and value
  task automatic pc(input logic [8:0] f, input logic [7:0] d,
                    input logic [3:0] oe, input logic [3:0] v);
    wr(upbpc_pkg::OFF_FSEL, 32'(f));
    wr(upbpc_pkg::OFF_DIR, 32'(d));
    wt(2);
    chk("fn_oe", 32'(pad_oe), 32'(oe));
    chk("fn_out", 32'(pad_out & oe), 32'(v));
  endtask : pc

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rck(upbpc_pkg::OFF_DIR, 32'h0000_00F0);
    rck(upbpc_pkg::OFF_IC2, 32'h0000_0080);
    rck(upbpc_pkg::OFF_ANA, 32'h0000_0000);
    rck(upbpc_pkg::OFF_LATCH, 32'h0000_0000);
    chk("pullup", 32'(pad_pullup_en), 32'h0000_0000);
    @(posedge aclk);
    pad_in <= 4'h1;
    wt(3);
    chk("periph4", 32'(periph_in[0]), 32'h0000_0000);
    rd(8'h2C, d, r); // hole in the map
    chk("hole_data", d, 32'h0000_0000);
    chk("hole_resp", 32'(r), 32'(upbpc_pkg::RESP_SLVERR));
  endtask : t_reset

  task automatic t_out();
    wr(upbpc_pkg::OFF_LATCH, 32'h0000_00A0);
    wr(upbpc_pkg::OFF_DIR, 32'h0000_0000);
    wt(2);
    chk("out", 32'(pad_out), 32'h0000_000A);
    chk("oe", 32'(pad_oe), 32'h0000_000F);
    wr(upbpc_pkg::OFF_LEVEL, 32'h0000_0050); // level write lands in latch
    wt(2);
    chk("out", 32'(pad_out), 32'h0000_0005);
    rck(upbpc_pkg::OFF_LATCH, 32'h0000_0050);
  endtask : t_out

  task automatic t_in();
    wr(upbpc_pkg::OFF_DIR, 32'h0000_00F0);
    wr(upbpc_pkg::OFF_ANA, 32'h0000_0010);
    pad_in <= 4'h9;
    wr(upbpc_pkg::OFF_IC2, 32'h0000_0000);
    wt(3);
    rck(upbpc_pkg::OFF_LEVEL, 32'h0000_0090);
    chk("periph", 32'(periph_in), 32'h0000_0009);
    chk("pullup", 32'(pad_pullup_en), 32'h0000_000F);
    ce <= 1'b0; // frozen: pin change must not reach periph_in
    pad_in <= 4'h1;
    wt(3);
    chk("ce_hold", 32'(periph_in), 32'h0000_0009);
    @(posedge aclk);
    ce <= 1'b1;
    pad_in <= 4'h9;
    wr(upbpc_pkg::OFF_ANA, 32'h0000_0000); // line 4 back to analog
    wt(3);
    rck(upbpc_pkg::OFF_LEVEL, 32'h0000_0080);
    chk("pullup", 32'(pad_pullup_en), 32'h0000_000E);
    wr(upbpc_pkg::OFF_IC2, 32'h0000_0080);
    wt(2);
    chk("pullup", 32'(pad_pullup_en), 32'h0000_0000);
  endtask : t_in

  task automatic t_fn();
    @(posedge aclk);
    remap_out <= 4'h6;
    par_addr_out <= 2'b10;
    sync_serial_clock_out <= 1'b1;
    two_wire_clock_out <= 1'b0; // pulls line 4 low
    two_wire_data_out <= 1'b1; // releases line 5
    wr(upbpc_pkg::OFF_LATCH, 32'h0000_0000);
    pc(9'h055, 8'h00, 4'hF, 4'h6);
    pc(9'h055, 8'hF0, 4'h0, 4'h0);
    pc(9'h00F, 8'h00, 4'hF, 4'h1);
    pc(9'h00F, 8'hF0, 4'h0, 4'h0);
    pc(9'h002, 8'h00, 4'hF, 4'h1);
    pc(9'h002, 8'hF0, 4'h0, 4'h0);
    pc(9'h10A, 8'h00, 4'hD, 4'h0);
    pc(9'h10A, 8'hF0, 4'h0, 4'h0);
    pc(9'h000, 8'hF0, 4'h0, 4'h0);
  endtask : t_fn

  task automatic t_prog();
    wr(upbpc_pkg::OFF_DIR, 32'h0000_0000);
    wr(upbpc_pkg::OFF_LATCH, 32'h0000_00F0);
    prog_mode <= 1'b1;
    prog_data_drive <= 1'b1;
    prog_data_out <= 1'b0;
    wt(2);
    chk("prog_oe", 32'(pad_oe), 32'h0000_000B);
    chk("prog_out", 32'(pad_out & 4'hB), 32'h0000_0003);
    @(posedge aclk);
    prog_data_drive <= 1'b0; // programmer takes the data line
    wt(2);
    chk("prog_oe", 32'(pad_oe), 32'h0000_0003);
    wr(upbpc_pkg::OFF_DIR, 32'h0000_00F0);
    wr(upbpc_pkg::OFF_IC2, 32'h0000_0000);
    prog_data_drive <= 1'b1;
    prog_data_out <= 1'b1;
    wt(2);
    chk("prog_oe", 32'(pad_oe), 32'h0000_0008);
    chk("prog_out", 32'(pad_out[3]), 32'h0000_0001);
    chk("prog_pull", 32'(pad_pullup_en), 32'h0000_0002);
    wr(upbpc_pkg::OFF_IC2, 32'h0000_0080);
    prog_mode <= 1'b0;
  endtask : t_prog

  task automatic t_irq();
    wr(upbpc_pkg::OFF_ANA, 32'h0000_0010);
    wr(upbpc_pkg::OFF_DIR, 32'h0000_0070); // line 7 output
    pad_in <= 4'h0;
    wt(3);
    wr(upbpc_pkg::OFF_ICLR, 32'h0000_0001);
    pad_in <= 4'h8;
    wt(4);
    rck(upbpc_pkg::OFF_ISTAT, 32'h0000_0000);
    wr(upbpc_pkg::OFF_DIR, 32'h0000_00F0);
    wt(3);
    wr(upbpc_pkg::OFF_ICLR, 32'h0000_0001);
    wr(upbpc_pkg::OFF_ICM, 32'h0000_0008);
    wr(upbpc_pkg::OFF_IEN, 32'h0000_0001);
    wr(upbpc_pkg::OFF_IC2, 32'h0000_0081);
    pad_in <= 4'h0;
    wt(4);
    rck(upbpc_pkg::OFF_ISTAT, 32'h0000_0001);
    rck(upbpc_pkg::OFF_ICM, 32'h0000_0009);
    chk("irq", 32'(irq), 32'h0000_0001);
    chk("irq_hi", 32'(irq_high), 32'h0000_0001);
    wr(upbpc_pkg::OFF_IC2, 32'h0000_0080);
    wt(2);
    chk("irq_lo", 32'(irq_low), 32'h0000_0001);
    chk("irq_hi", 32'(irq_high), 32'h0000_0000);
    wr(upbpc_pkg::OFF_IEN, 32'h0000_0000); // masked, status stays
    wt(2);
    chk("irq", 32'(irq), 32'h0000_0000);
    rck(upbpc_pkg::OFF_ISTAT, 32'h0000_0001);
    wr(upbpc_pkg::OFF_ICLR, 32'h0000_0001);
    wt(2);
    rck(upbpc_pkg::OFF_ISTAT, 32'h0000_0000);
    chk("irq_lo", 32'(irq_low), 32'h0000_0000);
  endtask : t_irq

  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, prog_mode, prog_data_out} = '0;
    {sync_serial_clock_out, two_wire_clock_out, two_wire_data_out} = '1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {pad_in, remap_out, par_addr_out, prog_data_drive} = '0;
    ce = 1'b1; // frozen only inside t_in
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_fn();
    t_prog();
    t_irq();
    report_and_stop();
  end
endmodule : tb_top

// ---- test/upbpc_assertions.sv ----
// upbpc_assertions: port-level checks for the upper port pin control.
// assumes one aclk domain; ce dropped only while the bus is idle.
`timescale 1ns/1ns
module upbpc_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] pad_pullup_en,
  input wire logic prog_mode,
  input wire logic prog_data_out,
  input wire logic prog_data_drive,
  input wire logic irq,
  input wire logic irq_high,
  input wire logic irq_low
);
  // ------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // programming held long enough for registered pads to follow
  sequence prog_on_s;
    prog_mode [*2];
  endsequence

  rst_quiet_a: assert property ($rose(aresetn) |-> pad_oe == 4'h0
    && pad_pullup_en == 4'h0 && !irq) else $error("pads busy at reset");
  wr_answer_a: assert property (wr_both_s |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write response held too long");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read data missing");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  pull_input_a: assert property ((pad_oe & pad_pullup_en) == 4'h0)
    else $error("pull-up on a driven line");
  prog_clk_a: assert property (prog_on_s |-> !pad_oe[2]
    && !pad_pullup_en[2]) else $error("prog clock line not input");
  prog_data_a: assert property (prog_on_s |->
    pad_oe[3] == $past(prog_data_drive) &&
    (!pad_oe[3] || pad_out[3] == $past(prog_data_out)))
    else $error("prog data line wrong");
  prio_excl_a: assert property (!(irq_high && irq_low))
    else $error("both priority requests high");
endmodule : upbpc_assertions

bind upbpc_top upbpc_assertions u_upbpc_assertions (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .pad_out, .pad_oe, .pad_pullup_en,
  .prog_mode, .prog_data_out, .prog_data_drive, .irq, .irq_high, .irq_low);
